/* File: rtl/usart_sdbt_defines.svh */
// register offsets, field positions and reset values of the status block
`ifndef USART_SDBT_DEFINES_SVH
`define USART_SDBT_DEFINES_SVH
`define OFS_IER        8'h08
`define OFS_IMR        8'h10
`define OFS_CSR        8'h14
`define OFS_RHR        8'h18
`define OFS_THR        8'h1C
`define OFS_BRGR       8'h20
`define OFS_RTOR       8'h24
`define OFS_CTRL       8'h00
`define OFS_MODE       8'h04
`define CSR_RESET      32'h0000_0018
`define B_RECEIVER_READY_FLAG        0
`define B_TRANSMITTER_READY_FLAG        1
`define B_BREAK_SEEN_FLAG        2
`define B_RECEIVE_TRANSFER_DONE        3
`define B_TRANSMIT_TRANSFER_DONE        4
`define B_OVERRUN_ERROR_FLAG         5
`define B_FRAME        6
`define B_PARITY_ERROR_FLAG         7
`define B_TIMEOUT      8
`define B_TRANSMITTER_IDLE_FLAG      9
`define CTL_RSTSTA     8
`define CTL_RXEN       4
`define CTL_RXDIS      5
`define CTL_TXEN       6
`define CTL_TXDIS      7
`define CTL_STTTO      11
`define CTL_START_BREAK_COMMAND     9
`define CTL_STPBRK     10
`define MODE_SYNC      8
`define MODE_EXTCLK    4
`define MODE_PARNONE   11
`define MODE_MULTIDROP 10
`define TO_BITS_PER    3'h4
`define OVS_ASYNC      5'h10
`endif

/* File: rtl/usart_sdbt_pkg.sv */
// types shared by the status, data, baud and time-out block
`default_nettype none
package usart_sdbt_pkg;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SHIFT,
        TX_BREAK
    } tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_DATA,
        RX_STOP,
        RX_BRKEND
    } rx_state_t;
endpackage
`default_nettype wire

/* File: rtl/baud_gen.sv */
// baud tick divider with bypass, stop and sixteen-times oversampling
`include "usart_sdbt_defines.svh"
`default_nettype none
module baud_gen (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // configuration
    input  wire logic [15:0] i_divisor,
    input  wire logic        i_sync,
    input  wire logic        i_ext_clk_tick,
    input  wire logic        i_ext_sel,
    // ticks
    output logic             o_bit_tick
);
    typedef struct packed {
        logic [15:0] div;
        logic [4:0]  ovs;
        logic        tick;
    } st_t;
    st_t s_q;
    st_t s_d;
    logic src_tick;
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        // synchronous mode on an external clock ignores the divisor
        src_tick = 1'b0;
        if (i_sync && i_ext_sel) begin
            s_d.tick = i_ext_clk_tick;
        end else if (i_divisor == 16'h0000) begin
            s_d.div = 16'h0000;
            s_d.ovs = 5'h00;
        end else begin
            if (i_divisor == 16'h0001) begin
                src_tick = i_ext_sel ? i_ext_clk_tick : 1'b1;
            end else if (s_q.div >= i_divisor - 16'h0001) begin
                s_d.div  = 16'h0000;
                src_tick = 1'b1;
            end else begin
                s_d.div = s_q.div + 16'h0001;
            end
            if (src_tick) begin
                if (i_sync) begin
                    s_d.tick = 1'b1;
                end else if (s_q.ovs == `OVS_ASYNC - 5'h01) begin
                    s_d.ovs  = 5'h00;
                    s_d.tick = 1'b1;
                end else begin
                    s_d.ovs = s_q.ovs + 5'h01;
                end
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_bit_tick = s_q.tick;
endmodule // baud_gen
`default_nettype wire

/* File: rtl/rx_timeout.sv */
// receive time-out counter in units of four bit periods
`include "usart_sdbt_defines.svh"
`default_nettype none
module rx_timeout (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // control
    input  wire logic [7:0] i_timeout_value,
    input  wire logic       i_start,
    input  wire logic       i_char_rx,
    input  wire logic       i_bit_tick,
    // status
    output logic            o_expired
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] sub;
        logic       armed;
        logic       started;
        logic       exp;
    } st_t;
    st_t s_q;
    st_t s_d;
    always_comb begin
        s_d = s_q;
        if (i_timeout_value == 8'h00) begin
            s_d     = '0;
        end else if (i_start) begin
            s_d.cnt     = i_timeout_value;
            s_d.sub     = 2'h0;
            s_d.armed   = 1'b0;
            s_d.started = 1'b0;
            s_d.exp     = 1'b0;
        end else if (i_char_rx) begin
            s_d.cnt     = i_timeout_value;
            s_d.sub     = 2'h0;
            s_d.armed   = 1'b1;
            s_d.started = 1'b1;
        end else if (s_q.armed && i_bit_tick) begin
            // one count per four bit periods
            if (s_q.sub == 2'(`TO_BITS_PER - 3'h1)) begin
                s_d.sub = 2'h0;
                if (s_q.cnt == 8'h01) begin
                    s_d.cnt   = 8'h00;
                    s_d.armed = 1'b0;
                    s_d.exp   = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end else begin
                s_d.sub = s_q.sub + 2'h1;
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_expired = s_q.exp;
endmodule // rx_timeout
`default_nettype wire

/* File: rtl/usart_sdbt.sv */
// status, holding registers, baud divisor and receive time-out of a uart
`include "usart_sdbt_defines.svh"
`default_nettype none
module usart_sdbt (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // serial line
    input  wire logic        i_rxd,
    input  wire logic        i_ext_clk,
    output logic             o_txd,
    // data transfer channel ends
    input  wire logic        i_receive_transfer_done,
    input  wire logic        i_transmit_transfer_done,
    // interrupt
    output logic             o_irq
);
    typedef struct packed {
        logic [31:0] rdata;
        logic [9:0]  mask;
        logic [15:0] divisor;
        logic [7:0]  tovalue;
        logic [15:0] mode;
        logic        rx_en;
        logic        tx_en;
        logic        receiver_ready_flag;
        logic        transmitter_ready_flag;
        logic        brk_req;
        logic        brk_stop_req;
        logic        brk_flag;
        logic        overrun_error_flag;
        logic        frame;
        logic        parity_error_flag;
        logic [7:0]  thr;
        logic [7:0]  rhr;
        usart_sdbt_pkg::tx_state_t tx_st;
        logic [9:0]  tx_sh;
        logic [3:0]  tx_cnt;
        usart_sdbt_pkg::rx_state_t rx_st;
        logic [8:0]  rx_sh;
        logic [3:0]  rx_cnt;
        logic [3:0]  rx_ph;
        logic        rx_zero;
        logic        txd;
        logic        irq;
        logic [2:0]  rxs;
        logic [2:0]  cks;
        logic        ck_last;
    } st_t;
    st_t s_q;
    st_t s_d;
    logic       bit_tick;
    logic       to_exp;
    logic       to_start;
    logic       char_rx;
    logic       ext_tick;
    logic       rx_in;
    logic       no_par;
    logic [9:0] csr;

    ////////////////////////////////////////////////////////////////////////
    baud_gen u_baud (
        .i_sys_clk     (i_sys_clk),
        .i_rst_n       (i_rst_n),
        .i_divisor     (s_q.divisor),
        .i_sync        (s_q.mode[`MODE_SYNC]),
        .i_ext_clk_tick(ext_tick),
        .i_ext_sel     (s_q.mode[`MODE_EXTCLK]),
        .o_bit_tick    (bit_tick)
    );
    rx_timeout u_to (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (i_rst_n),
        .i_timeout_value(s_q.tovalue),
        .i_start        (to_start),
        .i_char_rx      (char_rx),
        .i_bit_tick     (bit_tick),
        .o_expired      (to_exp)
    );

    ////////////////////////////////////////////////////////////////////////
    // pins are stable once the second and third stages agree
    assign rx_in    = (s_q.rxs[2] == s_q.rxs[1]) ? s_q.rxs[1] : s_q.rx_zero;
    assign ext_tick = (s_q.cks[2] == s_q.cks[1]) && s_q.cks[1] && !s_q.ck_last;
    assign to_start = (i_wr && i_addr == `OFS_RTOR)
                   || (i_wr && i_addr == `OFS_CTRL && i_wdata[`CTL_STTTO]);
    assign char_rx  = (s_q.rx_st == usart_sdbt_pkg::RX_STOP) && bit_tick;
    // multi-drop keeps its ninth bit, only the plain no-parity code drops it
    assign no_par   = s_q.mode[`MODE_PARNONE] && !s_q.mode[`MODE_MULTIDROP];

    always_comb begin
        csr                    = '0;
        csr[`B_RECEIVER_READY_FLAG]          = s_q.receiver_ready_flag;
        csr[`B_TRANSMITTER_READY_FLAG]          = s_q.transmitter_ready_flag && !s_q.brk_req;
        csr[`B_BREAK_SEEN_FLAG]          = s_q.brk_flag;
        csr[`B_RECEIVE_TRANSFER_DONE]          = i_receive_transfer_done;
        csr[`B_TRANSMIT_TRANSFER_DONE]          = i_transmit_transfer_done;
        csr[`B_OVERRUN_ERROR_FLAG]           = s_q.overrun_error_flag;
        csr[`B_FRAME]          = s_q.frame;
        csr[`B_PARITY_ERROR_FLAG]           = s_q.parity_error_flag;
        csr[`B_TIMEOUT]        = to_exp;
        csr[`B_TRANSMITTER_IDLE_FLAG]        = s_q.tx_en && s_q.tx_st == usart_sdbt_pkg::TX_IDLE
                               && s_q.transmitter_ready_flag && !s_q.brk_req;
    end

    always_comb begin
        s_d         = s_q;
        s_d.rxs     = {s_q.rxs[1:0], i_rxd};
        s_d.cks     = {s_q.cks[1:0], i_ext_clk};
        s_d.rx_zero = rx_in;
        if (s_q.cks[2] == s_q.cks[1]) begin
            s_d.ck_last = s_q.cks[1];
        end
        s_d.rdata = '0;
        // register reads: data stand one cycle
        if (i_rd) begin
            case (i_addr)
                `OFS_IMR:  s_d.rdata = {22'h000000, s_q.mask};
                `OFS_CSR:  s_d.rdata = {22'h000000, csr};
                `OFS_RHR:  s_d.rdata = {24'h000000, s_q.rhr};
                `OFS_BRGR: s_d.rdata = {16'h0000, s_q.divisor};
                `OFS_RTOR: s_d.rdata = {24'h000000, s_q.tovalue};
                `OFS_MODE: s_d.rdata = {16'h0000, s_q.mode};
                default:   s_d.rdata = '0;
            endcase
            if (i_addr == `OFS_RHR) begin
                s_d.receiver_ready_flag = 1'b0;
            end
        end
        if (i_wr) begin
            case (i_addr)
                `OFS_IER:  s_d.mask = s_q.mask | i_wdata[9:0];
                `OFS_BRGR: s_d.divisor = i_wdata[15:0];
                `OFS_RTOR: s_d.tovalue = i_wdata[7:0];
                `OFS_MODE: s_d.mode = i_wdata[15:0];
                `OFS_THR: begin
                    if (s_q.tx_en) begin
                        s_d.thr   = i_wdata[7:0];
                        s_d.transmitter_ready_flag = 1'b0;
                    end
                end
                `OFS_CTRL: begin
                    if (i_wdata[`CTL_RSTSTA]) begin
                        s_d.brk_flag = 1'b0;
                        s_d.overrun_error_flag     = 1'b0;
                        s_d.frame    = 1'b0;
                        s_d.parity_error_flag     = 1'b0;
                    end
                    if (i_wdata[`CTL_RXEN]) begin
                        s_d.rx_en = 1'b1;
                    end
                    if (i_wdata[`CTL_RXDIS]) begin
                        s_d.rx_en = 1'b0;
                        s_d.receiver_ready_flag = 1'b0;
                    end
                    if (i_wdata[`CTL_TXEN]) begin
                        s_d.tx_en = 1'b1;
                        s_d.transmitter_ready_flag = 1'b1;
                    end
                    if (i_wdata[`CTL_START_BREAK_COMMAND] && s_q.tx_en) begin
                        s_d.brk_req = 1'b1;
                    end
                    if (i_wdata[`CTL_STPBRK]) begin
                        s_d.brk_stop_req = 1'b1;
                    end
                    if (i_wdata[`CTL_TXDIS]) begin
                        s_d.tx_en   = 1'b0;
                        s_d.transmitter_ready_flag   = 1'b0;
                        s_d.brk_req = 1'b0;
                        s_d.tx_st   = usart_sdbt_pkg::TX_IDLE;
                        s_d.txd     = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // transmitter: holding moves on only after the current character
        if (s_q.tx_en && bit_tick) begin
            case (s_q.tx_st)
                usart_sdbt_pkg::TX_IDLE: begin
                    if (s_q.brk_req) begin
                        s_d.tx_st   = usart_sdbt_pkg::TX_BREAK;
                        s_d.brk_req = 1'b0;
                        s_d.txd     = 1'b0;
                    end else if (!s_q.transmitter_ready_flag) begin
                        s_d.tx_sh  = {1'b1, s_q.thr, 1'b0};
                        s_d.tx_cnt = 4'hA;
                        s_d.tx_st  = usart_sdbt_pkg::TX_SHIFT;
                        s_d.transmitter_ready_flag  = 1'b1;
                    end
                end
                usart_sdbt_pkg::TX_SHIFT: begin
                    s_d.txd    = s_q.tx_sh[0];
                    s_d.tx_sh  = {1'b1, s_q.tx_sh[9:1]};
                    s_d.tx_cnt = s_q.tx_cnt - 4'h1;
                    if (s_q.tx_cnt == 4'h1) begin
                        s_d.tx_st = usart_sdbt_pkg::TX_IDLE;
                    end
                end
                usart_sdbt_pkg::TX_BREAK: begin
                    if (s_q.brk_stop_req) begin
                        s_d.txd   = 1'b1;
                        s_d.tx_st = usart_sdbt_pkg::TX_IDLE;
                        s_d.brk_stop_req = 1'b0;
                    end
                end
                default: s_d.tx_st = usart_sdbt_pkg::TX_IDLE;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // receiver: one sample per bit tick, no mid-bit oversampling
        if (s_q.rx_en && bit_tick) begin
            case (s_q.rx_st)
                usart_sdbt_pkg::RX_IDLE: begin
                    if (!rx_in) begin
                        s_d.rx_cnt = 4'h0;
                        s_d.rx_st  = usart_sdbt_pkg::RX_DATA;
                    end
                end
                usart_sdbt_pkg::RX_DATA: begin
                    s_d.rx_sh  = {rx_in, s_q.rx_sh[8:1]};
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_cnt == (no_par ? 4'h7 : 4'h8)) begin
                        s_d.rx_st = usart_sdbt_pkg::RX_STOP;
                    end
                end
                usart_sdbt_pkg::RX_STOP: begin
                    s_d.rx_st = usart_sdbt_pkg::RX_IDLE;
                    s_d.rhr   = no_par ? s_q.rx_sh[8:1] : s_q.rx_sh[7:0];
                    if (s_q.receiver_ready_flag) begin
                        s_d.overrun_error_flag = 1'b1;
                    end
                    s_d.receiver_ready_flag = 1'b1;
                    if (!no_par
                        && (s_q.mode[`MODE_MULTIDROP] ? s_q.rx_sh[8]
                            : ^s_q.rx_sh)) begin
                        s_d.parity_error_flag = 1'b1;
                    end
                    if (!rx_in) begin
                        s_d.frame = 1'b1;
                        if (s_q.rx_sh == 9'h000) begin
                            s_d.brk_flag = 1'b1;
                            s_d.rx_st    = usart_sdbt_pkg::RX_BRKEND;
                        end
                    end
                end
                usart_sdbt_pkg::RX_BRKEND: begin
                    if (rx_in) begin
                        s_d.brk_flag = 1'b1;
                        s_d.rx_st    = usart_sdbt_pkg::RX_IDLE;
                    end
                end
                default: s_d.rx_st = usart_sdbt_pkg::RX_IDLE;
            endcase
        end
        if (!s_q.rx_en) begin
            s_d.receiver_ready_flag = 1'b0;
        end
        s_d.irq = |(csr & s_q.mask);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_q     <= '0;
            s_q.txd <= 1'b1;
            s_q.rxs <= 3'h7;
            s_q.rx_zero <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_txd   = s_q.txd;
    assign o_irq   = s_q.irq;
endmodule // usart_sdbt
`default_nettype wire

/* File: sim/usart_sdbt_props.sv */
// port-level assertions for the status, data, baud and time-out block
`include "usart_sdbt_defines.svh"
`default_nettype none
module usart_sdbt_props (
    // clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    // register port
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // line, channel ends, interrupt
    input wire logic        i_rxd,
    input wire logic        i_ext_clk,
    input wire logic        o_txd,
    input wire logic        i_receive_transfer_done,
    input wire logic        i_transmit_transfer_done,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////
    mask_width_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_IMR |-> o_rdata[31:10] == 22'h0)
        else $error("mask view has bits above the sources");
    rhr_width_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_RHR |-> o_rdata[31:8] == 24'h0)
        else $error("receive holding upper bits not zero");
    baud_width_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_BRGR |-> o_rdata[31:16] == 16'h0)
        else $error("baud divisor upper bits not zero");
    tout_width_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_RTOR |-> o_rdata[31:8] == 24'h0)
        else $error("time-out register upper bits not zero");
    status_ends_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_CSR && $stable(i_rxd | 1'h1)
        && $past(i_receive_transfer_done, 2) == $past(i_receive_transfer_done)
        |-> o_rdata[`B_RECEIVE_TRANSFER_DONE] == $past(i_receive_transfer_done))
        else $error("receive end bit does not follow its input");
    receiver_ready_flag_clear_a: assert property (
        $past(i_rd, 2) && $past(i_addr, 2) == `OFS_RHR && $past(i_rd)
        && $past(i_addr) == `OFS_CSR |-> !o_rdata[`B_RECEIVER_READY_FLAG])
        else $error("receiver ready not cleared by holding read");
    empty_ready_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_CSR && o_rdata[`B_TRANSMITTER_IDLE_FLAG]
        |-> o_rdata[`B_TRANSMITTER_READY_FLAG])
        else $error("transmitter empty without transmitter ready");
    irq_unmasked_a: assert property (
        $past(i_rd) && $past(i_addr) == `OFS_IMR && o_rdata == 32'h0
        |-> !o_irq)
        else $error("interrupt raised with no source enabled");
    reset_quiet_a: assert property (
        $rose(i_rst_n) |-> o_txd && !o_irq ##1 o_txd)
        else $error("line or interrupt active after reset");
endmodule // usart_sdbt_props
bind usart_sdbt usart_sdbt_props u_props (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rxd(i_rxd), .i_ext_clk(i_ext_clk), .o_txd(o_txd),
    .i_receive_transfer_done(i_receive_transfer_done),
    .i_transmit_transfer_done(i_transmit_transfer_done), .o_irq(o_irq));
`default_nettype wire

/* File: sim/serial_peer.sv */
// far-end serial peer: supplies the bit clock, sends and captures bits
`default_nettype none
module serial_peer (
    // clock
    input  wire logic i_sys_clk,
    // line
    input  wire logic i_line_tx,
    output logic      o_ext_clk,
    output logic      o_rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tx_seen[$];
    initial begin
        o_ext_clk = 1'h0;
        o_rxd     = 1'h1;
    end
    // clock stands still between calls; callers end with idle ones
    task automatic run(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            o_rxd <= bits[i];
            repeat (8) @(posedge i_sys_clk);
            o_ext_clk <= 1'h1;
            repeat (8) @(posedge i_sys_clk);
            tx_seen.push_back(i_line_tx);
            o_ext_clk <= 1'h0;
        end
    endtask
endmodule // serial_peer
`default_nettype wire

/* File: sim/usart_sdbt_tb.sv */
// self-checking bench for the status, data, baud and time-out block
`include "usart_sdbt_defines.svh"
`default_nettype none
module usart_sdbt_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
    localparam logic [31:0] TXOK = 32'h0000_0202;
    logic        i_sys_clk;
    logic        i_rst_n;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        i_rxd;
    logic        i_ext_clk;
    logic        o_txd;
    logic        i_receive_transfer_done;
    logic        i_transmit_transfer_done;
    logic        o_irq;
    int          n_mismatch;
    int          comparisons;
    int          seed;
    logic [31:0] exp_mask;
    logic [31:0] got;
    logic [31:0] v;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  rx_q[$];
    logic [7:0]  tx_q[$];
    usart_sdbt DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_rxd(i_rxd), .i_ext_clk(i_ext_clk),
        .o_txd(o_txd), .i_receive_transfer_done(i_receive_transfer_done),
        .i_transmit_transfer_done(i_transmit_transfer_done), .o_irq(o_irq));
    serial_peer peer (.i_sys_clk(i_sys_clk), .i_line_tx(o_txd),
        .o_ext_clk(i_ext_clk), .o_rxd(i_rxd));
    initial begin
        i_sys_clk = 1'h0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] bv(input int n);
        return 32'h1 << n;
    endfunction
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'h1;
        @(posedge i_sys_clk);
        i_wr    <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'h1;
        @(posedge i_sys_clk);
        i_rd   <= 1'h0;
        #1 got = o_rdata;
        chk(got & m, e);
    endtask
    task automatic stchk(input logic [31:0] m, input logic [31:0] e);
        rdchk(`OFS_CSR, m, e);
        if (m === ALL) chk({31'h0, o_irq}, {31'h0, |(e & exp_mask)});
    endtask
    task automatic rx_frame(input logic [7:0] d, input logic stp);
        rx_q.push_back(d);
        peer.run({22'h3FFFFF, stp, d, 1'h0}, 14);
    endtask
    task automatic tx_decode();
        int i;
        logic [7:0] d;
        i = 0;
        while (i + 9 < peer.tx_seen.size()) begin
            if (peer.tx_seen[i] === 1'h0) begin
                for (int k = 0; k < 8; k++) d[k] = peer.tx_seen[i + 1 + k];
                chk({24'h0, d}, {24'h0, tx_q.pop_front()});
                i += 10;
            end else begin
                i++;
            end
        end
        chk(tx_q.size(), 32'h0);
        peer.tx_seen.delete();
    endtask
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        i_rst_n = 1'h0;
        i_addr = 8'h0;
        i_wdata = 32'h0;
        i_wr = 1'h0;
        i_rd = 1'h0;
        i_receive_transfer_done = 1'h0;
        i_transmit_transfer_done = 1'h0;
        seed = 32'h6b72;
        exp_mask = 32'h0;
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'h1;
        stchk(ALL, 32'h0);
        rdchk(`OFS_RHR, ALL, 32'h0);
        rdchk(`OFS_BRGR, ALL, 32'h0);
        rdchk(`OFS_RTOR, ALL, 32'h0);
        rdchk(`OFS_IMR, ALL, 32'h0);
        rdchk(8'h40, ALL, 32'h0);
        i_receive_transfer_done <= 1'h1;
        stchk(ALL, bv(`B_RECEIVE_TRANSFER_DONE));
        i_receive_transfer_done <= 1'h0;
        i_transmit_transfer_done <= 1'h1;
        stchk(ALL, bv(`B_TRANSMIT_TRANSFER_DONE));
        i_transmit_transfer_done <= 1'h0;
        // external clock chosen, so the bypass value is never a hazard
        wr(`OFS_MODE, bv(`MODE_SYNC) | bv(`MODE_EXTCLK) | bv(`MODE_PARNONE));
        wr(`OFS_CTRL, bv(`CTL_RXEN) | bv(`CTL_TXEN));
        stchk(ALL, TXOK);
        v = $random(seed) & 32'hFFFF_FFFE;
        wr(`OFS_BRGR, v);
        rdchk(`OFS_BRGR, ALL, v & 32'hFFFF);
        for (int n = 0; n < 3; n++) begin
            v = $random(seed);
            wr(`OFS_IER, v);
            exp_mask |= v & 32'h3FF;
            rdchk(`OFS_IMR, ALL, exp_mask);
        end
        wr(`OFS_IER, 32'h0);
        rdchk(`OFS_IMR, ALL, exp_mask);
        b1 = $random(seed);
        rx_frame(b1, 1'h1);
        stchk(ALL, TXOK | bv(`B_RECEIVER_READY_FLAG));
        rdchk(`OFS_RHR, ALL, {24'h0, rx_q.pop_front()});
        stchk(ALL, TXOK);
        b2 = $random(seed);
        rx_frame(b1, 1'h1);
        rx_frame(b2, 1'h1);
        stchk(ALL, TXOK | bv(`B_RECEIVER_READY_FLAG) | bv(`B_OVERRUN_ERROR_FLAG));
        void'(rx_q.pop_front());
        rdchk(`OFS_RHR, ALL, {24'h0, rx_q.pop_front()});
        stchk(ALL, TXOK | bv(`B_OVERRUN_ERROR_FLAG));
        wr(`OFS_CTRL, bv(`CTL_RSTSTA));
        stchk(ALL, TXOK);
        rx_frame(8'h55, 1'h0);
        void'(rx_q.pop_front());
        stchk(~bv(`B_RECEIVER_READY_FLAG), TXOK | bv(`B_FRAME));
        wr(`OFS_CTRL, bv(`CTL_RSTSTA));
        stchk(~bv(`B_RECEIVER_READY_FLAG), TXOK);
        peer.run({18'h3FFFF, 14'h0}, 32);
        stchk(bv(`B_BREAK_SEEN_FLAG), bv(`B_BREAK_SEEN_FLAG));
        peer.run(ALL, 4);
        stchk(bv(`B_BREAK_SEEN_FLAG), bv(`B_BREAK_SEEN_FLAG));
        rdchk(`OFS_RHR, 32'h0, 32'h0);
        wr(`OFS_CTRL, bv(`CTL_RSTSTA));
        stchk(ALL, TXOK);
        wr(`OFS_MODE, bv(`MODE_SYNC) | bv(`MODE_EXTCLK) | bv(`MODE_PARNONE)
            | bv(`MODE_MULTIDROP));
        b1 = $random(seed);
        peer.run({21'h1FFFFF, 1'h1, 1'h1, b1, 1'h0}, 16);
        stchk(bv(`B_PARITY_ERROR_FLAG), bv(`B_PARITY_ERROR_FLAG));
        rdchk(`OFS_RHR, ALL, {24'h0, b1});
        wr(`OFS_MODE, bv(`MODE_SYNC) | bv(`MODE_EXTCLK) | bv(`MODE_PARNONE));
        wr(`OFS_CTRL, bv(`CTL_RSTSTA));
        stchk(ALL, TXOK);
        peer.tx_seen.delete();
        b1 = $random(seed);
        b2 = $random(seed);
        v = $random(seed);
        tx_q.push_back(b1);
        tx_q.push_back(b2);
        wr(`OFS_THR, {v[31:8], b1});
        stchk(bv(`B_TRANSMITTER_IDLE_FLAG), 32'h0);
        peer.run(ALL, 1);
        wr(`OFS_THR, {v[31:8], b2});
        stchk(TXOK, 32'h0);
        peer.run(ALL, 28);
        tx_decode();
        stchk(ALL, TXOK);
        wr(`OFS_CTRL, bv(`CTL_START_BREAK_COMMAND));
        stchk(TXOK, 32'h0);
        wr(`OFS_CTRL, bv(`CTL_STPBRK));
        peer.run(ALL, 16);
        peer.tx_seen.delete();
        stchk(ALL, TXOK);
        v = $random(seed);
        wr(`OFS_RTOR, v);
        rdchk(`OFS_RTOR, ALL, v & 32'hFF);
        wr(`OFS_RTOR, 32'h2);
        b1 = $random(seed);
        rx_frame(b1, 1'h1);
        stchk(bv(`B_TIMEOUT), 32'h0);
        rdchk(`OFS_RHR, ALL, {24'h0, rx_q.pop_front()});
        peer.run(ALL, 3);
        stchk(bv(`B_TIMEOUT), 32'h0);
        peer.run(ALL, 2);
        stchk(bv(`B_TIMEOUT), bv(`B_TIMEOUT));
        wr(`OFS_RTOR, 32'h2);
        stchk(bv(`B_TIMEOUT), 32'h0);
        wr(`OFS_RTOR, 32'h0);
        peer.run(ALL, 12);
        stchk(ALL, TXOK);
        complete_run();
    end
endmodule // usart_sdbt_tb
`default_nettype wire
